// *** core/tba_exec.sv ***
// Execution unit for table reads, carry bit moves, add, subtract and AND.
// Assumes program and data memories answer one cycle after the address.
`timescale 1ns/1ps
module tba_exec (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input tba_pkg::tba_cmd_type cmd_i,
  input wire logic [tba_pkg::PC_W-1:0] pc_i,
  input wire logic [7:0] pmem_data_i,
  input wire logic [3:0] dmem_rdata_i,
  output logic ready_o,
  output logic done_o,
  output logic skip_pend_o,
  output logic carry_flag_o,
  output logic [7:0][7:0] regs_o,
  output logic [tba_pkg::PM_AW-1:0] pmem_addr_o,
  output logic [tba_pkg::DM_AW-1:0] dmem_addr_o,
  output logic dmem_we_o,
  output logic [3:0] dmem_wdata_o
);
  tba_pkg::tba_state_type state;
  tba_pkg::tba_cmd_type cur;
  logic [7:0][7:0] regs;
  logic carry_flag;
  logic skip_pend;
  logic dec_arm;
  logic dec_skp;
  logic nosk;
  logic [1:0] cur_bit;
  logic take;
  logic drop;
  logic run;
  logic mem_op;
  logic [5:0] page;
  logic [tba_pkg::PM_AW-1:0] t_addr;
  logic [tba_pkg::DM_AW-1:0] b_addr;
  logic [1:0] b_bit;
  logic k_add;
  logic k_sub;
  logic k_skip;
  logic k_carry;
  logic narrow;
  logic [2:0] dst;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum;
  logic [8:0] res;
  logic flag;

  // Outputs straight from state flops
  assign regs_o = regs;
  assign carry_flag_o = carry_flag;
  assign skip_pend_o = skip_pend;

  // Command acceptance and the skipped-instruction decision
  assign take = ready_o && cmd_i.valid;
  assign drop = skip_pend || (dec_arm && dec_skp && cmd_i.op == tba_pkg::OP_SKADD_NIB);
  assign run = take && !drop;

  // Commands that wait one cycle for program or data memory
  always_comb begin
    unique case (cmd_i.op)
      tba_pkg::OP_TBL_PC, tba_pkg::OP_TBL_ABS, tba_pkg::OP_TBL_BCACC, tba_pkg::OP_BIT_LOAD,
      tba_pkg::OP_BIT_STORE, tba_pkg::OP_SKADD_MEM, tba_pkg::OP_CADD_MEM, tba_pkg::OP_SKSUB_MEM,
      tba_pkg::OP_BSUB_MEM, tba_pkg::OP_AND_MEM: mem_op = 1'b1;
      default: mem_op = 1'b0;
    endcase
  end

  // Table address; page steps when the instruction ends its page
  always_comb begin
    page = pc_i[13:8] + ((pc_i[7:0] == tba_pkg::PAGE_LAST) ? tba_pkg::PAGE_STEP : 6'h00);
    unique case (cmd_i.op)
      tba_pkg::OP_TBL_ABS: t_addr = {regs[tba_pkg::PAIR_BC][6:0], regs[tba_pkg::PAIR_DE]};
      tba_pkg::OP_TBL_BCACC: t_addr = {regs[tba_pkg::PAIR_BC][6:0], regs[tba_pkg::PAIR_ACC]};
      default: t_addr = {1'b0, page, regs[tba_pkg::PAIR_ACC]};
    endcase
  end

  // Bit addressing modes
  always_comb begin
    unique case (cmd_i.bmode)
      tba_pkg::BM_FIXED: begin
        b_addr = cmd_i.imm;
        b_bit = cmd_i.bsel;
      end
      tba_pkg::BM_PORT_L: begin
        b_addr = {cmd_i.imm[7:2], regs[tba_pkg::PAIR_PTR][3:2]};
        b_bit = regs[tba_pkg::PAIR_PTR][1:0];
      end
      tba_pkg::BM_H_BASE: begin
        b_addr = {regs[tba_pkg::PAIR_PTR][7:4], cmd_i.imm[3:0]};
        b_bit = cmd_i.bsel;
      end
      default: begin
        b_addr = cmd_i.imm;
        b_bit = cmd_i.bsel;
      end
    endcase
  end

  // Operand selection and class of the command in execution
  always_comb begin
    k_add = 1'b0;
    k_sub = 1'b0;
    k_skip = 1'b0;
    k_carry = 1'b0;
    narrow = 1'b1;
    dst = tba_pkg::PAIR_ACC;
    opa = {4'h0, regs[tba_pkg::PAIR_ACC][3:0]};
    opb = {4'h0, dmem_rdata_i};
    unique case (cur.op)
      tba_pkg::OP_SKADD_NIB: begin
        k_add = 1'b1;
        k_skip = 1'b1;
        opb = {4'h0, cur.imm[3:0]};
      end
      tba_pkg::OP_SKADD_BYTE: begin
        k_add = 1'b1;
        k_skip = 1'b1;
        narrow = 1'b0;
        opa = regs[tba_pkg::PAIR_ACC];
        opb = cur.imm;
      end
      tba_pkg::OP_SKADD_MEM: begin
        k_add = 1'b1;
        k_skip = 1'b1;
      end
      tba_pkg::OP_CADD_MEM: begin
        k_add = 1'b1;
        k_carry = 1'b1;
      end
      tba_pkg::OP_SKSUB_MEM: begin
        k_sub = 1'b1;
        k_skip = 1'b1;
      end
      tba_pkg::OP_BSUB_MEM: begin
        k_sub = 1'b1;
        k_carry = 1'b1;
      end
      tba_pkg::OP_AND_NIB: opb = {4'h0, cur.imm[3:0]};
      tba_pkg::OP_SKADD_PAIR, tba_pkg::OP_CADD_PAIR, tba_pkg::OP_SKSUB_PAIR,
      tba_pkg::OP_BSUB_PAIR, tba_pkg::OP_AND_PAIR: begin
        narrow = 1'b0;
        k_add = (cur.op == tba_pkg::OP_SKADD_PAIR) || (cur.op == tba_pkg::OP_CADD_PAIR);
        k_sub = (cur.op == tba_pkg::OP_SKSUB_PAIR) || (cur.op == tba_pkg::OP_BSUB_PAIR);
        k_skip = (cur.op == tba_pkg::OP_SKADD_PAIR) || (cur.op == tba_pkg::OP_SKSUB_PAIR);
        k_carry = (cur.op == tba_pkg::OP_CADD_PAIR) || (cur.op == tba_pkg::OP_BSUB_PAIR);
        opa = cur.rev ? regs[cur.pair] : regs[tba_pkg::PAIR_ACC];
        opb = cur.rev ? regs[tba_pkg::PAIR_ACC] : regs[cur.pair];
        dst = cur.rev ? cur.pair : tba_pkg::PAIR_ACC;
      end
      default: narrow = 1'b1;
    endcase
  end

  // Shared adder, subtractor and AND; flag is carry or borrow
  always_comb begin
    cin = k_carry & carry_flag;
    sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    if (k_add) begin
      res = sum;
    end else if (k_sub) begin
      res = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    end else begin
      res = {1'b0, opa & opb};
    end
    flag = narrow ? res[tba_pkg::NIB_CARRY] : res[tba_pkg::BYTE_CARRY];
  end

  // Sequencer: idle, memory wait, execute
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= tba_pkg::S_IDLE;
      ready_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      unique case (state)
        tba_pkg::S_IDLE: begin
          ready_o <= 1'b1;
          if (take && drop) begin
            done_o <= 1'b1;
          end else if (run) begin
            ready_o <= 1'b0;
            state <= mem_op ? tba_pkg::S_WAIT : tba_pkg::S_EXEC;
          end
        end
        tba_pkg::S_WAIT: state <= tba_pkg::S_EXEC;
        default: begin
          state <= tba_pkg::S_IDLE;
          ready_o <= 1'b1;
          done_o <= 1'b1;
        end
      endcase
    end
  end

  // Captured command and memory addresses
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
      cur_bit <= 2'h0;
      nosk <= 1'b0;
      pmem_addr_o <= '0;
      dmem_addr_o <= '0;
    end else if (ce_i && state == tba_pkg::S_IDLE && run) begin
      cur <= cmd_i;
      cur_bit <= b_bit;
      nosk <= dec_arm && cmd_i.op == tba_pkg::OP_SKADD_NIB;
      pmem_addr_o <= t_addr;
      dmem_addr_o <= (cmd_i.op == tba_pkg::OP_BIT_LOAD || cmd_i.op == tba_pkg::OP_BIT_STORE)
        ? b_addr : regs[tba_pkg::PAIR_PTR];
    end
  end

  // Data memory write for the bit store
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dmem_we_o <= 1'b0;
      dmem_wdata_o <= 4'h0;
    end else if (ce_i) begin
      dmem_we_o <= 1'b0;
      if (state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_BIT_STORE) begin
        dmem_we_o <= 1'b1;
        dmem_wdata_o <= dmem_rdata_i;
        dmem_wdata_o[cur_bit] <= carry_flag;
      end
    end
  end

  // Register pairs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regs <= {8{tba_pkg::REG_RST}};
    end else if (ce_i && state == tba_pkg::S_EXEC) begin
      unique case (cur.op)
        tba_pkg::OP_TBL_PC, tba_pkg::OP_TBL_ABS, tba_pkg::OP_TBL_BCACC:
          regs[tba_pkg::PAIR_ACC] <= pmem_data_i;
        tba_pkg::OP_BIT_LOAD, tba_pkg::OP_BIT_STORE, tba_pkg::OP_LOAD_CARRY: ;
        tba_pkg::OP_LOAD_PAIR: regs[cur.pair] <= cur.imm;
        default: begin
          if (narrow) begin
            regs[tba_pkg::PAIR_ACC][3:0] <= res[3:0];
          end else begin
            regs[dst] <= res[7:0];
          end
        end
      endcase
    end
  end

  // Carry flag
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_flag <= tba_pkg::CARRY_RST;
    end else if (ce_i && state == tba_pkg::S_EXEC) begin
      if (cur.op == tba_pkg::OP_BIT_LOAD) begin
        carry_flag <= dmem_rdata_i[cur_bit];
      end else if (cur.op == tba_pkg::OP_LOAD_CARRY) begin
        carry_flag <= cur.imm[0];
      end else if (k_carry) begin
        carry_flag <= flag;
      end
    end
  end

  // Skip and decimal adjust tracking
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_pend <= 1'b0;
      dec_arm <= 1'b0;
      dec_skp <= 1'b0;
    end else if (ce_i) begin
      if (state == tba_pkg::S_IDLE && take) begin
        skip_pend <= 1'b0;
        dec_arm <= 1'b0;
      end else if (state == tba_pkg::S_EXEC) begin
        skip_pend <= k_skip && flag && !nosk;
        if (cur.op == tba_pkg::OP_CADD_MEM || cur.op == tba_pkg::OP_BSUB_MEM) begin
          dec_arm <= 1'b1;
          dec_skp <= (cur.op == tba_pkg::OP_CADD_MEM) ? flag : !flag;
        end
      end
    end
  end

  default clocking cb @(posedge clock_i iff ce_i); endclocking
  default disable iff (!rst_n_i);

  tbl_page_step_a: assert property (
    run && cmd_i.op == tba_pkg::OP_TBL_PC && pc_i[7:0] == tba_pkg::PAGE_LAST
    |=> pmem_addr_o[13:8] == $past(pc_i[13:8]) + tba_pkg::PAGE_STEP)
    else $error("table page did not step");
  tbl_pc_index_a: assert property (
    run && cmd_i.op == tba_pkg::OP_TBL_PC |=> pmem_addr_o[7:0] == $past(regs[0]))
    else $error("table index wrong");
  tbl_abs_addr_a: assert property (
    run && cmd_i.op == tba_pkg::OP_TBL_ABS
    |=> pmem_addr_o == {$past(regs[3][6:0]), $past(regs[2])})
    else $error("absolute table address wrong");
  tbl_load_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_TBL_BCACC
    |=> regs_o[0] == $past(pmem_data_i) && done_o)
    else $error("table byte not loaded");
  bit_load_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_BIT_LOAD
    |=> carry_flag_o == $past(dmem_rdata_i[cur_bit]))
    else $error("bit load wrong");
  bit_store_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_BIT_STORE
    |=> dmem_we_o && dmem_wdata_o[cur_bit] == $past(carry_flag) ##1 !dmem_we_o)
    else $error("bit store write missing");
  skip_keep_carry_a: assert property (
    state == tba_pkg::S_EXEC && k_skip |=> carry_flag_o == $past(carry_flag))
    else $error("skip op changed carry");
  skipped_nop_a: assert property (
    take && skip_pend |=> regs_o == $past(regs) && carry_flag_o == $past(carry_flag)
    && done_o && !skip_pend_o && !dmem_we_o)
    else $error("skipped op had effect");
  dec_carry_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_CADD_MEM
    |=> dec_arm && dec_skp == carry_flag_o)
    else $error("carry-add adjust state wrong");
  dec_borrow_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_BSUB_MEM
    |=> dec_arm && dec_skp == !carry_flag_o)
    else $error("borrow-sub adjust state wrong");
  and_nib_a: assert property (
    state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_AND_NIB
    |=> regs_o[0][3:0] == ($past(regs[0][3:0]) & $past(cur.imm[3:0])))
    else $error("nibble AND wrong");

  page_end_c: cover property (run && cmd_i.op == tba_pkg::OP_TBL_PC
    && pc_i[7:0] == tba_pkg::PAGE_LAST);
  dec_adjust_c: cover property (take && dec_arm && cmd_i.op == tba_pkg::OP_SKADD_NIB);
  bit_store_c: cover property (state == tba_pkg::S_EXEC && cur.op == tba_pkg::OP_BIT_STORE);
endmodule

// *** core/tba_pkg.sv ***
// Constants, types and the command layout of the table, bit and arithmetic unit.
// Assumes one clock, synchronous memories with one cycle of read latency.
// Operation
// - PC table read: accumulator pair replaces low 8 PC bits; byte splits to X and A
// - Table reads leave PC alone; page comes from PC of the table instruction
// - PC table read at page's last address takes data from the next page
// - Absolute table read addresses low three bits of B, then C, D, E
// - B-C-accumulator table read addresses B low bits, C, X, A
// - Bit load copies one addressed data bit into the carry flag
// - Bit store writes carry into one data bit, other bits kept
// - Nibble immediate skip-add skips on nibble carry, carry flag kept
// - Byte immediate skip-add skips on byte carry, carry flag kept
// - Memory skip-add adds pointed nibble, skips on carry, carry kept
// - Pair skip-adds in either direction, result to destination, skip on carry
// - Memory carry-add adds nibble and carry, carry follows result
// - After carry-add with carry next nibble skip-add skipped, else no skip
// - Pair carry-add in either direction, destination and carry updated
// - Memory skip-subtract, skip on borrow, carry kept
// - Pair skip-subtract in either direction, minuend written, skip on borrow
// - Memory borrow-subtract subtracts nibble and carry, carry shows borrow
// - After borrow-subtract without borrow next nibble skip-add skipped, else no skip
// - Pair borrow-subtract in either direction, minuend and carry written
// - Nibble immediate AND into accumulator
// - AND with pointed nibble into accumulator; AND with any register pair in either direction, result to destination
package tba_pkg;
  localparam int PC_W = 14;
  localparam int PM_AW = 15;
  localparam int DM_AW = 8;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam logic [5:0] PAGE_STEP = 6'h01;
  localparam logic [2:0] PAIR_ACC = 3'h0;
  localparam logic [2:0] PAIR_PTR = 3'h1;
  localparam logic [2:0] PAIR_DE = 3'h2;
  localparam logic [2:0] PAIR_BC = 3'h3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam int NIB_CARRY = 4;
  localparam int BYTE_CARRY = 8;
  typedef enum logic [4:0] {
    OP_TBL_PC = 5'h00, OP_TBL_ABS = 5'h01, OP_TBL_BCACC = 5'h02,
    OP_BIT_LOAD = 5'h03, OP_BIT_STORE = 5'h04,
    OP_SKADD_NIB = 5'h05, OP_SKADD_BYTE = 5'h06, OP_SKADD_MEM = 5'h07,
    OP_SKADD_PAIR = 5'h08, OP_CADD_MEM = 5'h09, OP_CADD_PAIR = 5'h0A,
    OP_SKSUB_MEM = 5'h0B, OP_SKSUB_PAIR = 5'h0C, OP_BSUB_MEM = 5'h0D,
    OP_BSUB_PAIR = 5'h0E, OP_AND_NIB = 5'h0F, OP_AND_MEM = 5'h10,
    OP_AND_PAIR = 5'h11, OP_LOAD_PAIR = 5'h12, OP_LOAD_CARRY = 5'h13
  } tba_op_type;
  typedef enum logic [1:0] {
    BM_FIXED = 2'h0, BM_PORT_L = 2'h1, BM_H_BASE = 2'h2
  } tba_bmode_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_WAIT = 2'h1, S_EXEC = 2'h2
  } tba_state_type;
  typedef struct packed {
    logic valid;
    tba_op_type op;
    logic [2:0] pair;
    logic rev;
    logic [7:0] imm;
    tba_bmode_type bmode;
    logic [1:0] bsel;
  } tba_cmd_type;
endpackage

// *** tb/table_bit_arith_exec_test.sv ***
// Self-checking bench for the table, bit and arithmetic execution unit.
// Assumes tba_mem_model answers for program and data memory.
`timescale 1ns/1ps
module table_bit_arith_exec_test;
  logic clock_i;
  logic rst_n_i;
  logic ce_i;
  tba_pkg::tba_cmd_type cmd_i;
  logic [13:0] pc_i;
  logic [7:0] pm_data;
  logic [3:0] dm_rdata;
  logic ready_o, done_o, skip_pend_o, carry_flag_o, dmem_we_o;
  logic [7:0][7:0] regs_o;
  logic [14:0] pmem_addr_o;
  logic [7:0] dmem_addr_o;
  logic [3:0] dmem_wdata_o;
  int err_total;
  int n_tests;

  tba_exec dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cmd_i(cmd_i),
    .pc_i(pc_i), .pmem_data_i(pm_data), .dmem_rdata_i(dm_rdata), .ready_o(ready_o),
    .done_o(done_o), .skip_pend_o(skip_pend_o), .carry_flag_o(carry_flag_o),
    .regs_o(regs_o), .pmem_addr_o(pmem_addr_o), .dmem_addr_o(dmem_addr_o),
    .dmem_we_o(dmem_we_o), .dmem_wdata_o(dmem_wdata_o));
  tba_mem_model mem_u (.clock_i(clock_i), .pmem_addr_i(pmem_addr_o), .pmem_data_o(pm_data),
    .dmem_addr_i(dmem_addr_o), .dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o),
    .dmem_rdata_o(dm_rdata));

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected memory contents
  function automatic logic [7:0] pmv(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  function automatic logic [3:0] dmv(input logic [7:0] a);
    return a[3:0] ^ a[7:4];
  endfunction

  // Issue one command and wait for its completion pulse
  task automatic run(input tba_pkg::tba_op_type op, input logic [2:0] pr, input logic rv,
                     input logic [7:0] imm, input logic [1:0] bm = 2'h0,
                     input logic [1:0] bs = 2'h0);
    int n;
    n = 0;
    @(negedge clock_i);
    while (ready_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    cmd_i = '{1'b1, op, pr, rv, imm, tba_pkg::tba_bmode_type'(bm), bs};
    @(negedge clock_i);
    cmd_i.valid = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    chk(done_o, 1'b1);
    chk(ready_o, 1'b1);
  endtask

  // Preload helpers
  task automatic ld(input logic [2:0] pr, input logic [7:0] v);
    run(tba_pkg::OP_LOAD_PAIR, pr, 1'b0, v);
  endtask
  task automatic ldc(input logic v);
    run(tba_pkg::OP_LOAD_CARRY, 3'h0, 1'b0, {7'h00, v});
  endtask

  // Table reads in all three address forms
  task automatic test_table();
    ld(3'h0, 8'h5A);
    pc_i = 14'h0123;
    run(tba_pkg::OP_TBL_PC, 3'h0, 1'b0, 8'h00);
    chk(pmem_addr_o, 15'h015A);
    chk(regs_o[0], pmv(15'h015A));
    ld(3'h0, 8'h5A);
    pc_i = 14'h02FF;
    run(tba_pkg::OP_TBL_PC, 3'h0, 1'b0, 8'h00);
    chk(pmem_addr_o, 15'h035A);
    ld(3'h3, 8'h9C);
    ld(3'h2, 8'h3E);
    run(tba_pkg::OP_TBL_ABS, 3'h0, 1'b0, 8'h00);
    chk(pmem_addr_o, 15'h1C3E);
    chk(regs_o[0], pmv(15'h1C3E));
    ld(3'h0, 8'h7D);
    run(tba_pkg::OP_TBL_BCACC, 3'h0, 1'b0, 8'h00);
    chk(pmem_addr_o, 15'h1C7D);
    chk(regs_o[0], pmv(15'h1C7D));
    $display("test_table finished");
  endtask

  // Carry bit load and store in each bit addressing mode
  task automatic test_bits();
    logic [7:0] ptr;
    logic [7:0] a;
    logic [1:0] b;
    logic [3:0] nib;
    logic [3:0] ex;
    logic v;
    logic [7:0] im [3];
    logic [1:0] bsl [3];
    ptr = 8'h4B;
    im = '{8'h35, 8'h80, 8'h07};
    bsl = '{2'h2, 2'h0, 2'h1};
    ld(3'h1, ptr);
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? im[i] : (i == 1) ? {im[i][7:2], ptr[3:2]} : {ptr[7:4], im[i][3:0]};
      b = (i == 1) ? ptr[1:0] : bsl[i];
      nib = dmv(a);
      v = nib[b];
      ex = nib;
      ex[b] = !v;
      ldc(!v);
      run(tba_pkg::OP_BIT_LOAD, 3'h0, 1'b0, im[i], i[1:0], bsl[i]);
      chk(dmem_addr_o, a);
      chk(carry_flag_o, v);
      ldc(!v);
      run(tba_pkg::OP_BIT_STORE, 3'h0, 1'b0, im[i], i[1:0], bsl[i]);
      chk(dmem_we_o, 1'b1);
      chk(dmem_wdata_o, ex);
      ldc(v);
      run(tba_pkg::OP_BIT_LOAD, 3'h0, 1'b0, im[i], i[1:0], bsl[i]);
      chk(carry_flag_o, !v);
    end
    $display("test_bits finished");
  endtask

  // One arithmetic case; a skip is followed by a command that must do nothing
  task automatic acase(input logic c0, input logic [7:0] acc, input logic [2:0] pi,
                       input logic [7:0] pv, input tba_pkg::tba_op_type op,
                       input logic [2:0] pr, input logic rv, input logic [7:0] imm,
                       input logic [2:0] ri, input logic [7:0] ev, input logic sk,
                       input logic cf);
    ldc(c0);
    ld(3'h0, acc);
    ld(pi, pv);
    run(op, pr, rv, imm);
    chk(regs_o[ri], ev);
    chk(skip_pend_o, sk);
    chk(carry_flag_o, cf);
    if (sk) begin
      run(tba_pkg::OP_LOAD_PAIR, 3'h5, 1'b0, 8'hEE);
      chk(regs_o[5], 8'h11);
      chk(skip_pend_o, 1'b0);
    end
  endtask

  // Skip-adds, carry-adds, subtracts and ANDs
  task automatic test_arith();
    ld(3'h5, 8'h11);
    acase(1, 8'h0C, 1, 8'h2B, tba_pkg::OP_SKADD_NIB, 0, 0, 8'h05, 0, 8'h01, 1, 1);
    acase(1, 8'h0C, 1, 8'h2B, tba_pkg::OP_SKADD_NIB, 0, 0, 8'h03, 0, 8'h0F, 0, 1);
    acase(0, 8'hF0, 1, 8'h2B, tba_pkg::OP_SKADD_BYTE, 0, 0, 8'h20, 0, 8'h10, 1, 0);
    acase(1, 8'h3A, 1, 8'h2B, tba_pkg::OP_SKADD_MEM, 0, 0, 8'h00, 0, 8'h33, 1, 1);
    acase(0, 8'h80, 6, 8'h90, tba_pkg::OP_SKADD_PAIR, 6, 0, 8'h00, 0, 8'h10, 1, 0);
    acase(0, 8'h80, 6, 8'h30, tba_pkg::OP_SKADD_PAIR, 6, 1, 8'h00, 6, 8'hB0, 0, 0);
    acase(1, 8'hF0, 3, 8'h0F, tba_pkg::OP_CADD_PAIR, 3, 0, 8'h00, 0, 8'h00, 0, 1);
    acase(1, 8'h10, 3, 8'h20, tba_pkg::OP_CADD_PAIR, 3, 1, 8'h00, 3, 8'h31, 0, 0);
    acase(0, 8'h05, 1, 8'h2B, tba_pkg::OP_SKSUB_MEM, 0, 0, 8'h00, 0, 8'h0C, 1, 0);
    acase(1, 8'h20, 2, 8'h30, tba_pkg::OP_SKSUB_PAIR, 2, 0, 8'h00, 0, 8'hF0, 1, 1);
    acase(0, 8'h20, 2, 8'h30, tba_pkg::OP_SKSUB_PAIR, 2, 1, 8'h00, 2, 8'h10, 0, 0);
    acase(1, 8'h10, 3, 8'h10, tba_pkg::OP_BSUB_PAIR, 3, 0, 8'h00, 0, 8'hFF, 0, 1);
    acase(0, 8'h20, 3, 8'h50, tba_pkg::OP_BSUB_PAIR, 3, 1, 8'h00, 3, 8'h30, 0, 0);
    acase(0, 8'h5E, 1, 8'h2B, tba_pkg::OP_AND_NIB, 0, 0, 8'h03, 0, 8'h52, 0, 0);
    acase(0, 8'h0F, 1, 8'h2B, tba_pkg::OP_AND_MEM, 0, 0, 8'h00, 0, 8'h09, 0, 0);
    acase(0, 8'hF0, 7, 8'h3C, tba_pkg::OP_AND_PAIR, 7, 0, 8'h00, 0, 8'h30, 0, 0);
    acase(0, 8'hF0, 7, 8'h3C, tba_pkg::OP_AND_PAIR, 7, 1, 8'h00, 7, 8'h30, 0, 0);
    $display("test_arith finished");
  endtask

  // Memory add or subtract with carry, then the nibble adjust that follows it
  task automatic adj(input logic c0, input logic [7:0] acc, input tba_pkg::tba_op_type op,
                     input logic [3:0] ea, input logic cf, input logic [7:0] im,
                     input logic [3:0] ea2);
    ldc(c0);
    ld(3'h0, acc);
    ld(3'h1, 8'h2B);
    run(op, 3'h0, 1'b0, 8'h00);
    chk(regs_o[0][3:0], ea);
    chk(carry_flag_o, cf);
    run(tba_pkg::OP_SKADD_NIB, 3'h0, 1'b0, im);
    chk(regs_o[0][3:0], ea2);
    chk(skip_pend_o, 1'b0);
  endtask

  // Decimal adjust pairs in all four outcomes
  task automatic test_adjust();
    adj(1, 8'h06, tba_pkg::OP_CADD_MEM, 4'h0, 1, 8'h06, 4'h0);
    adj(0, 8'h05, tba_pkg::OP_CADD_MEM, 4'hE, 0, 8'h06, 4'h4);
    adj(1, 8'h0B, tba_pkg::OP_BSUB_MEM, 4'h1, 0, 8'h06, 4'h1);
    adj(0, 8'h05, tba_pkg::OP_BSUB_MEM, 4'hC, 1, 8'h0A, 4'h6);
    $display("test_adjust finished");
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    cmd_i = '0;
    pc_i = '0;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    test_table();
    test_bits();
    test_arith();
    test_adjust();
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule

// *** tb/tba_mem_model.sv ***
// Program and data memory behind the execution unit.
// Assumes addresses are registered by the unit; data follows one cycle later.
`timescale 1ns/1ps
module tba_mem_model (
  input wire logic clock_i,
  input wire logic [14:0] pmem_addr_i,
  output logic [7:0] pmem_data_o,
  input wire logic [7:0] dmem_addr_i,
  input wire logic dmem_we_i,
  input wire logic [3:0] dmem_wdata_i,
  output logic [3:0] dmem_rdata_o
);
  logic [3:0] mem [0:255];
  // Known nibble pattern so the bench can predict contents
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[3:0] ^ i[7:4];
    end
    pmem_data_o = 8'h00;
    dmem_rdata_o = 4'h0;
  end
  // One cycle of read latency; write lands on the strobe edge
  always @(posedge clock_i) begin
    pmem_data_o <= pmem_addr_i[7:0] ^ {1'b0, pmem_addr_i[14:8]};
    dmem_rdata_o <= mem[dmem_addr_i];
    if (dmem_we_i) begin
      mem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule
